//--- dv/ccm_props.sv
/*
  Checker for the clock and mode configuration block.
  Assumes it is bound to ccm_top and sees only its ports.
*/
module ccm_props
  import ccm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ccm_bus_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire logic single_chip,
  input wire logic nmi_req,
  input wire ccm_clk_ctl_t clk_ctl,
  input wire ccm_mode_ctl_t mode_ctl,
  input wire logic nmi_take
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // A second write to the same place would overtake the first
  sequence s_wr(logic [15:0] a);
    bus_req.wr && bus_req.addr == a ##1 !(bus_req.wr && bus_req.addr == a);
  endsequence
  chk_losc_stop: assert property (
    s_wr(CCM_OFS_CMODE1) |=>
      clk_ctl.losc_run == !$past(bus_req.wdata[4], 2))
    else $error("losc_run wrong");
  chk_fb_res: assert property (
    s_wr(CCM_OFS_CMODE1) |=>
      clk_ctl.fb_connect == !$past(bus_req.wdata[3], 2))
    else $error("fb_connect wrong");
  chk_pll_div: assert property (
    s_wr(CCM_OFS_PLLC) |=>
      clk_ctl.pll_refdiv == $past(bus_req.wdata[5:4], 2))
    else $error("pll_refdiv wrong");
  chk_pll_mult: assert property (
    s_wr(CCM_OFS_PLLC) |=>
      clk_ctl.pll_mult == $past(bus_req.wdata[2:0], 2))
    else $error("pll_mult wrong");
  chk_nmi_enable: assert property (
    s_wr(CCM_OFS_PMODE2) |=>
      mode_ctl.nmi_accept == $past(bus_req.wdata[4], 2))
    else $error("nmi_accept wrong");
  chk_nmi_gate: assert property (
    nmi_take == ($past(nmi_req) && mode_ctl.nmi_accept))
    else $error("nmi_take wrong");
  chk_sub_supply: assert property (
    s_wr(CCM_OFS_PMODE2) |=>
      mode_ctl.subclock_supply == $past(bus_req.wdata[5], 2))
    else $error("subclock_supply wrong");
  chk_flash_map: assert property (
    s_wr(CCM_OFS_PMODE1) |=>
      mode_ctl.data_flash_map == $past(bus_req.wdata[0], 2))
    else $error("data_flash_map wrong");
endmodule // ccm_props

bind ccm_top ccm_props u_props (.clk_sys, .sys_rst, .bus_req, .rdata,
  .single_chip, .nmi_req, .clk_ctl, .mode_ctl, .nmi_take);

//--- dv/tb_top.sv
/*
  Self-checking bench for ccm_top.
  Assumes the checker is bound in from ccm_props.sv.
*/
module tb_top import ccm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, sys_rst, single_chip, nmi_req, nmi_take;
  logic [7:0] rdata, d;
  ccm_bus_req_t bus_req;
  ccm_clk_ctl_t clk_ctl;
  ccm_mode_ctl_t mode_ctl;
  int errors, cmp_count;
  // Offset, write data, read-back; the last row is unmapped
  localparam logic [31:0] ROWS [10] = '{32'h0005_0101, 32'h0006_0202,
    32'h0007_1818, 32'h0010_5A5A, 32'h0012_2020, 32'h0016_A5A5,
    32'h001C_3737, 32'h001E_3030, 32'h0222_0606, 32'h0040_FF00};
  ccm_top u_dut (.clk_sys, .sys_rst, .bus_req, .rdata, .single_chip,
    .nmi_req, .clk_ctl, .mode_ctl, .nmi_take);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] v);
    @(posedge clk_sys);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a);
    @(posedge clk_sys);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task give_verdict;
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    bus_req = '0;
    single_chip = 1'b0;
    nmi_req = 1'b0;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle;
    chk("clk_rst", clk_ctl,
      {4'hC, 3'h1, CCM_CPU_DIV_RESET, CCM_CO_SUB});
    rd(CCM_OFS_CMODE1);
    chk("cm1_rst", d, CCM_RST_CMODE1);
    foreach (ROWS[i]) begin
      wr(ROWS[i][31:16], ROWS[i][15:8]);
      rd(ROWS[i][31:16]);
      chk("readback", d, ROWS[i][7:0]);
    end
    settle;
    chk("clk_cfg", clk_ctl,
      {4'h3, 3'h7, CCM_CPU_DIV_ONE, CCM_CO_F32});
    chk("mode_cfg", mode_ctl,
      {5'h1F, 8'hA5});
    @(posedge clk_sys);
    single_chip <= 1'b1;
    nmi_req <= 1'b1;
    settle;
    chk("clkout_ext", clk_ctl.clkout_sel, CCM_CO_F1);
    chk("nmi_on", nmi_take, 1'b1);
    wr(CCM_OFS_PMODE2, 8'h20);
    wr(CCM_OFS_PCS, 8'h00);
    settle;
    chk("nmi_off", nmi_take, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wr(CCM_OFS_CMODE0, 8'(k));
      settle;
      chk("clkout_sel", clk_ctl.clkout_sel,
        (k == 3) ? 2'h0 : 2'(k));
    end
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(CCM_OFS_PMODE2);
    chk("pm2_rst", d, CCM_RST_PMODE2);
    give_verdict;
  end
  // The whole sequence needs under a hundred cycles
  initial begin
    repeat (2000) @(posedge clk_sys);
    errors++;
    give_verdict;
  end
endmodule // tb_top

//--- rtl/ccm_pkg.sv
/*
  Package for the clock and mode configuration bits: register offsets,
  field positions, reset values and the carrier structs.
  Assumes a plain register port with read data one cycle after the strobe.
*/
package ccm_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] CCM_OFS_PMODE1 = 16'h0005;
  localparam logic [15:0] CCM_OFS_CMODE1 = 16'h0007;
  localparam logic [15:0] CCM_OFS_CMODE0 = 16'h0006;
  localparam logic [15:0] CCM_OFS_WP2 = 16'h0010;
  localparam logic [15:0] CCM_OFS_PCS = 16'h0012;
  localparam logic [15:0] CCM_OFS_PCSTP1 = 16'h0016;
  localparam logic [15:0] CCM_OFS_PLLC = 16'h001C;
  localparam logic [15:0] CCM_OFS_PMODE2 = 16'h001E;
  localparam logic [15:0] CCM_OFS_FM2 = 16'h0222;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CCM_PMODE1_AREA = 0;
  localparam int CCM_CMODE0_SEL_LO = 0;
  localparam int CCM_CMODE0_SEL_HI = 1;
  localparam int CCM_CMODE1_FB_OFF = 3;
  localparam int CCM_CMODE1_LOSC_STOP = 4;
  localparam int CCM_CMODE1_DIV_SEL = 5;
  localparam int CCM_PCS_EXT = 5;
  localparam int CCM_PLC_MULT_LSB = 0;
  localparam int CCM_PLC_REFDIV_LSB = 4;
  localparam int CCM_PMODE2_NMI = 4;
  localparam int CCM_PMODE2_SUB = 5;
  localparam int CCM_FM2_SLOW = 1;
  localparam int CCM_FM2_LOWCUR = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CCM_RST_PMODE1 = 8'h00;
  localparam logic [7:0] CCM_RST_CMODE0 = 8'h00;
  localparam logic [7:0] CCM_RST_CMODE1 = 8'h20;
  localparam logic [7:0] CCM_RST_WP2 = 8'h00;
  localparam logic [7:0] CCM_RST_PCS = 8'h00;
  localparam logic [7:0] CCM_RST_PCSTP1 = 8'h00;
  localparam logic [7:0] CCM_RST_PLLC = 8'h01;
  localparam logic [7:0] CCM_RST_PMODE2 = 8'h00;
  localparam logic [7:0] CCM_RST_FM2 = 8'h00;
  localparam logic [3:0] CCM_CPU_DIV_RESET = 4'h8;
  localparam logic [3:0] CCM_CPU_DIV_ONE = 4'h1;

  // Clock output sources
  typedef enum logic [1:0] {
    CCM_CO_SUB = 2'h0,
    CCM_CO_F8 = 2'h1,
    CCM_CO_F32 = 2'h2,
    CCM_CO_F1 = 2'h3
  } ccm_clkout_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccm_bus_req_t;

  typedef struct packed {
    logic losc_run;
    logic fb_connect;
    logic [1:0] pll_refdiv;
    logic [2:0] pll_mult;
    logic [3:0] cpu_div;
    ccm_clkout_t clkout_sel;
  } ccm_clk_ctl_t;

  typedef struct packed {
    logic nmi_accept;
    logic subclock_supply;
    logic data_flash_map;
    logic flash_slow_read;
    logic flash_lowcur_read;
    logic [7:0] periph_stop;
  } ccm_mode_ctl_t;

endpackage : ccm_pkg

//--- rtl/ccm_top.sv
/*
  Clock and processor-mode configuration register block. Holds the
  software-written bits and turns them into steady control levels for the
  oscillators, PLL, clock output, NMI gate and memory map.
  Assumes a single-master register port synchronous to clk_sys.
*/
module ccm_top
  import ccm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ccm_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic single_chip,
  input wire logic nmi_req,
  output ccm_clk_ctl_t clk_ctl,
  output ccm_mode_ctl_t mode_ctl,
  output logic nmi_take
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] pmode1_q, cmode0_q, cmode1_q, wp2_q, pcs_q, pcstp1_q;
  logic [7:0] pllc_q, pmode2_q, fm2_q;
  logic [7:0] rdata_d;
  ccm_clk_ctl_t clk_ctl_d;
  ccm_mode_ctl_t mode_ctl_d;

  function automatic logic hit(input logic [15:0] ofs);
    hit = bus_req.wr && (bus_req.addr == ofs);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pmode1_q <= CCM_RST_PMODE1;
      cmode0_q <= CCM_RST_CMODE0;
      cmode1_q <= CCM_RST_CMODE1;
      wp2_q <= CCM_RST_WP2;
      pcs_q <= CCM_RST_PCS;
      pcstp1_q <= CCM_RST_PCSTP1;
      pllc_q <= CCM_RST_PLLC;
      pmode2_q <= CCM_RST_PMODE2;
      fm2_q <= CCM_RST_FM2;
    end else begin
      if (hit(CCM_OFS_PMODE1)) pmode1_q <= bus_req.wdata;
      if (hit(CCM_OFS_CMODE0)) cmode0_q <= bus_req.wdata;
      if (hit(CCM_OFS_CMODE1)) cmode1_q <= bus_req.wdata;
      if (hit(CCM_OFS_WP2)) wp2_q <= bus_req.wdata;
      if (hit(CCM_OFS_PCS)) pcs_q <= bus_req.wdata;
      if (hit(CCM_OFS_PCSTP1)) pcstp1_q <= bus_req.wdata;
      if (hit(CCM_OFS_PLLC)) pllc_q <= bus_req.wdata;
      if (hit(CCM_OFS_PMODE2)) pmode2_q <= bus_req.wdata;
      if (hit(CCM_OFS_FM2)) fm2_q <= bus_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero
  always_comb begin
    rdata_d = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        CCM_OFS_PMODE1: rdata_d = pmode1_q;
        CCM_OFS_CMODE0: rdata_d = cmode0_q;
        CCM_OFS_CMODE1: rdata_d = cmode1_q;
        CCM_OFS_WP2: rdata_d = wp2_q;
        CCM_OFS_PCS: rdata_d = pcs_q;
        CCM_OFS_PCSTP1: rdata_d = pcstp1_q;
        CCM_OFS_PLLC: rdata_d = pllc_q;
        CCM_OFS_PMODE2: rdata_d = pmode2_q;
        CCM_OFS_FM2: rdata_d = fm2_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) rdata <= 8'h00;
    else rdata <= rdata_d;
  end

  // ----------------------------------------------------------------
  // Clock control
  // ----------------------------------------------------------------
  always_comb begin
    clk_ctl_d.losc_run = ~cmode1_q[CCM_CMODE1_LOSC_STOP];
    clk_ctl_d.fb_connect = ~cmode1_q[CCM_CMODE1_FB_OFF];
    clk_ctl_d.pll_refdiv =
      pllc_q[CCM_PLC_REFDIV_LSB +: 2];
    clk_ctl_d.pll_mult = pllc_q[CCM_PLC_MULT_LSB +: 3];
    clk_ctl_d.cpu_div = cmode1_q[CCM_CMODE1_DIV_SEL] ?
      CCM_CPU_DIV_RESET : CCM_CPU_DIV_ONE;
    // Extension only honoured in single-chip mode
    if (single_chip && pcs_q[CCM_PCS_EXT]) begin
      clk_ctl_d.clkout_sel = CCM_CO_F1;
    end else begin
      case ({cmode0_q[CCM_CMODE0_SEL_HI], cmode0_q[CCM_CMODE0_SEL_LO]})
        2'h1: clk_ctl_d.clkout_sel = CCM_CO_F8;
        2'h2: clk_ctl_d.clkout_sel = CCM_CO_F32;
        default: clk_ctl_d.clkout_sel = CCM_CO_SUB;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  always_comb begin
    mode_ctl_d.nmi_accept = pmode2_q[CCM_PMODE2_NMI];
    mode_ctl_d.subclock_supply = pmode2_q[CCM_PMODE2_SUB];
    mode_ctl_d.data_flash_map = pmode1_q[CCM_PMODE1_AREA];
    mode_ctl_d.flash_slow_read = fm2_q[CCM_FM2_SLOW];
    mode_ctl_d.flash_lowcur_read = fm2_q[CCM_FM2_LOWCUR];
    mode_ctl_d.periph_stop = pcstp1_q;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clk_ctl <= '0;
      mode_ctl <= '0;
      nmi_take <= 1'b0;
    end else begin
      clk_ctl <= clk_ctl_d;
      mode_ctl <= mode_ctl_d;
      // Gate follows the registered enable so both move together
      nmi_take <= nmi_req && pmode2_q[CCM_PMODE2_NMI];
    end
  end

endmodule // ccm_top
